// ==== hdl/lfc_core.sv ====
// Operation
// - boost output code 3.8V to 5.2V in 100mV steps, written serially
// - boost stays off while code zero; rectifier on while code zero if any sink drives current
// - flash sink gets movie level up to 160mA, flash up to 320mA
// - flash mode entered only by flash enable rising; code alone never flashes
// - duration timer 0.5s to 2.0s ends flash even with enable high
// - flash setting wins over movie setting when both requested
// - four independent five-bit sink codes, off or 31 levels
// - everything disabled while undervoltage lockout indication is active
// - standby when all off and inputs low, serial port still ready
// - open and short indications merged into one fault bit per sink
// - fault detection only for enabled sinks with nonzero code
// - read at 0x95 latches fault bits then shifts them out
// - over temperature turns everything off, restart via soft start
// - default source drives movie current once nonzero code written
// - gated source drives movie current only while movie input high
// - slave only, serial clock never driven
// - control byte is three-bit command plus five-bit data
// - START/STOP framing, ninth clock carries receiver acknowledge
// - command msb first; 000 voltage, 001-100 sinks, 110 flash, 111 movie
// - command 111 with bit4 clear stores four-bit movie code
// - flash ends on enable low or timeout, movie level resumes
// - command 111 with bit4 set, bit2 selects movie gating
// - low two bits select 0.5s, 1.0s, 1.5s or 2.0s
// - status byte flash fault bit4, sinks four to one bits3 to 0
`timescale 1ns/1ps
`default_nettype none
module lfc_core #(
  parameter int FLASH_STEP = lfc_pkg::FLASH_STEP_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic FLASH_ENABLE_INPUT,
  input wire logic MOVIE_ON_INPUT,
  input wire logic UNDERVOLTAGE_LOCKOUT,
  input wire logic OVER_TEMP,
  input wire logic [4:0] OPEN_DETECT,
  input wire logic [4:0] SHORT_DETECT,
  output logic [3:0] BOOST_VOLTAGE_CODE,
  output logic BOOST_ENABLE,
  output logic SYNC_RECT_ON,
  output logic [19:0] LED_SINK_CODE,
  output logic [4:0] FLASH_SINK_CODE,
  output logic FLASH_MODE,
  output logic MOVIE_MODE,
  output logic [4:0] DETECT_ENABLE,
  output logic STANDBY
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  lfc_pkg::lfc_pins_t pin_meta;
  lfc_pkg::lfc_pins_t pin_s;
  lfc_pkg::lfc_pins_t pin_raw;

  assign pin_raw = '{short_det: SHORT_DETECT, open_det: OPEN_DETECT, over_temp: OVER_TEMP,
                     undervoltage_lockout: UNDERVOLTAGE_LOCKOUT, movie_on: MOVIE_ON_INPUT,
                     flash_enable: FLASH_ENABLE_INPUT, sda: SDA_IN, scl: SCL};

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_meta <= '{scl: 1'b1, sda: 1'b1, default: '0}; // bus lines idle high
      pin_s <= '{scl: 1'b1, sda: 1'b1, default: '0};
    end else begin
      pin_meta <= pin_raw;
      pin_s <= pin_meta;
    end
  end

  // ----------------------------------------
  // control byte decode
  // ----------------------------------------
  function automatic lfc_pkg::lfc_cfg_t apply_byte(input lfc_pkg::lfc_cfg_t cur,
                                                   input logic [7:0] b);
    lfc_pkg::lfc_cfg_t res;
    logic [2:0] cmd;
    logic [4:0] data;
    res = cur;
    cmd = b[lfc_pkg::CMD_MSB_POS:lfc_pkg::CMD_LSB_POS];
    data = b[lfc_pkg::SEL_BIT_POS:0];
    if (cmd == lfc_pkg::CMD_BOOST) begin
      if (!data[lfc_pkg::SEL_BIT_POS]) begin
        res.boost_voltage_code = data[3:0];
      end
    end else if (cmd >= lfc_pkg::CMD_SINK1 && cmd <= lfc_pkg::CMD_SINK4) begin
      res.sink_current_code[cmd - lfc_pkg::CMD_SINK1] = data;
    end else if (cmd == lfc_pkg::CMD_FLASH) begin
      res.flash_current_code = data;
    end else if (cmd == lfc_pkg::CMD_MOVIE) begin
      if (!data[lfc_pkg::SEL_BIT_POS]) begin
        res.movie_current_code = data[3:0];
      end else begin
        res.movie_gated = data[lfc_pkg::GATE_BIT_POS];
        res.flash_duration = data[1:0];
      end
    end
    // reserved 101 and 000 with bit4 set fall through untouched
    return res;
  endfunction : apply_byte

  // ----------------------------------------
  // serial slave
  // ----------------------------------------
  lfc_pkg::lfc_state_t state;
  lfc_pkg::lfc_state_t next_state;
  lfc_pkg::lfc_cfg_t cfg;
  lfc_pkg::lfc_cfg_t next_cfg;
  logic scl_d;
  logic sda_d;
  logic [7:0] rx_shift;
  logic [7:0] next_rx_shift;
  logic [7:0] tx_shift;
  logic [7:0] next_tx_shift;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic drive;
  logic next_drive;
  logic drive_bit;
  logic next_drive_bit;
  logic is_read;
  logic next_is_read;
  logic [7:0] status;
  logic [7:0] next_status;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic lockout;
  logic [4:0] fault;

  assign scl_rise = pin_s.scl & ~scl_d;
  assign scl_fall = ~pin_s.scl & scl_d;
  assign start_cond = pin_s.scl & scl_d & sda_d & ~pin_s.sda;
  assign stop_cond = pin_s.scl & scl_d & ~sda_d & pin_s.sda;
  assign lockout = pin_s.undervoltage_lockout | pin_s.over_temp;

  always_comb begin
    next_state = state;
    next_cfg = cfg;
    next_rx_shift = rx_shift;
    next_tx_shift = tx_shift;
    next_bit_cnt = bit_cnt;
    next_drive = drive;
    next_drive_bit = drive_bit;
    next_is_read = is_read;
    next_status = status;
    if (start_cond) begin
      next_state = lfc_pkg::ST_ADDR;
      next_bit_cnt = '0;
      next_drive = 1'b0;
    end else if (stop_cond) begin
      next_state = lfc_pkg::ST_IDLE;
      next_drive = 1'b0;
    end else begin
      unique case (state)
        lfc_pkg::ST_IDLE, lfc_pkg::ST_SKIP: begin
          next_drive = 1'b0;
        end
        lfc_pkg::ST_ADDR: begin
          if (scl_rise) begin
            next_rx_shift = {rx_shift[6:0], pin_s.sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'(lfc_pkg::BYTE_BITS)) begin
            if (rx_shift == lfc_pkg::ADDR_WRITE) begin
              next_state = lfc_pkg::ST_AACK;
              next_is_read = 1'b0;
              next_drive = 1'b1;
              next_drive_bit = 1'b0;
            end else if (rx_shift == lfc_pkg::ADDR_READ) begin
              next_state = lfc_pkg::ST_AACK;
              next_is_read = 1'b1;
              next_drive = 1'b1;
              next_drive_bit = 1'b0;
              next_status = {lfc_pkg::STATUS_PAD, fault};
            end else begin
              next_state = lfc_pkg::ST_SKIP;
            end
          end
        end
        lfc_pkg::ST_AACK: begin
          if (scl_fall) begin
            next_bit_cnt = '0;
            if (is_read) begin
              next_state = lfc_pkg::ST_RDATA;
              next_tx_shift = status;
              next_drive_bit = status[7];
            end else begin
              next_state = lfc_pkg::ST_WDATA;
              next_drive = 1'b0;
            end
          end
        end
        lfc_pkg::ST_WDATA: begin
          if (scl_rise) begin
            next_rx_shift = {rx_shift[6:0], pin_s.sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'(lfc_pkg::BYTE_BITS)) begin
            next_state = lfc_pkg::ST_WACK;
            next_drive = 1'b1;
            next_drive_bit = 1'b0;
            next_cfg = apply_byte(cfg, rx_shift);
          end
        end
        lfc_pkg::ST_WACK: begin
          if (scl_fall) begin
            next_state = lfc_pkg::ST_SKIP;
            next_drive = 1'b0;
          end
        end
        lfc_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == 4'(lfc_pkg::BYTE_BITS - 1)) begin
              next_state = lfc_pkg::ST_RACK;
              next_drive = 1'b0;
            end else begin
              next_bit_cnt = bit_cnt + 4'h1;
              next_tx_shift = {tx_shift[6:0], 1'b0};
              next_drive_bit = tx_shift[6];
            end
          end
        end
        lfc_pkg::ST_RACK: begin
          if (scl_rise) begin
            next_is_read = ~pin_s.sda;
          end else if (scl_fall) begin
            if (is_read) begin
              next_state = lfc_pkg::ST_RDATA;
              next_bit_cnt = '0;
              next_status = {lfc_pkg::STATUS_PAD, fault};
              next_tx_shift = {lfc_pkg::STATUS_PAD, fault};
              next_drive_bit = lfc_pkg::STATUS_PAD[2];
              next_drive = 1'b1;
            end else begin
              next_state = lfc_pkg::ST_SKIP;
            end
          end
        end
        default: begin
          next_state = lfc_pkg::ST_IDLE;
          next_drive = 1'b0;
        end
      endcase
    end
    if (pin_s.undervoltage_lockout) begin
      next_cfg = lfc_pkg::CFG_RESET;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= lfc_pkg::ST_IDLE;
      cfg <= lfc_pkg::CFG_RESET;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      rx_shift <= '0;
      tx_shift <= '0;
      bit_cnt <= '0;
      drive <= 1'b0;
      drive_bit <= 1'b0;
      is_read <= 1'b0;
      status <= '0;
    end else begin
      state <= next_state;
      cfg <= next_cfg;
      scl_d <= pin_s.scl;
      sda_d <= pin_s.sda;
      rx_shift <= next_rx_shift;
      tx_shift <= next_tx_shift;
      bit_cnt <= next_bit_cnt;
      drive <= next_drive;
      drive_bit <= next_drive_bit;
      is_read <= next_is_read;
      status <= next_status;
    end
  end

  // ----------------------------------------
  // flash and movie arbitration
  // ----------------------------------------
  logic flash_enable_input_d;
  logic flash_active;
  logic next_flash_active;
  logic [lfc_pkg::FLASH_CNT_W-1:0] tick;
  logic [lfc_pkg::FLASH_CNT_W-1:0] next_tick;
  logic [1:0] step;
  logic [1:0] next_step;
  logic movie_req;
  logic [4:0] applied;
  logic [4:0] sink_on;
  logic [4:0] det_en;

  assign movie_req = (cfg.movie_current_code != 4'h0) &&
                     (!cfg.movie_gated || pin_s.movie_on);

  always_comb begin
    next_flash_active = flash_active;
    next_tick = tick;
    next_step = step;
    if (lockout || !pin_s.flash_enable) begin
      next_flash_active = 1'b0;
    end else if (!flash_enable_input_d) begin
      next_flash_active = 1'b1;
      next_tick = '0;
      next_step = '0;
    end else if (flash_active) begin
      if (tick == lfc_pkg::FLASH_CNT_W'(FLASH_STEP - 1)) begin
        next_tick = '0;
        next_step = step + 2'h1;
        if (step == cfg.flash_duration) begin
          next_flash_active = 1'b0;
        end
      end else begin
        next_tick = tick + lfc_pkg::FLASH_CNT_W'(1);
      end
    end
    if (flash_active) begin
      applied = cfg.flash_current_code;
    end else if (movie_req) begin
      applied = {1'b0, cfg.movie_current_code};
    end else begin
      applied = '0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < lfc_pkg::SINK_COUNT; gi++) begin : g_sink
      assign sink_on[gi] = (cfg.sink_current_code[gi] != 5'h00) && !lockout;
    end
  endgenerate
  assign sink_on[lfc_pkg::SINK_COUNT] = (applied != 5'h00) && !lockout;
  assign det_en = sink_on;
  assign fault = det_en & (pin_s.open_det | pin_s.short_det);

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flash_enable_input_d <= 1'b0;
      flash_active <= 1'b0;
      tick <= '0;
      step <= '0;
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      BOOST_VOLTAGE_CODE <= '0;
      BOOST_ENABLE <= 1'b0;
      SYNC_RECT_ON <= 1'b0;
      LED_SINK_CODE <= '0;
      FLASH_SINK_CODE <= '0;
      FLASH_MODE <= 1'b0;
      MOVIE_MODE <= 1'b0;
      DETECT_ENABLE <= '0;
      STANDBY <= 1'b1;
    end else begin
      flash_enable_input_d <= pin_s.flash_enable;
      flash_active <= next_flash_active;
      tick <= next_tick;
      step <= next_step;
      SDA_OUT <= drive_bit;
      SDA_OE <= drive & ~drive_bit;
      BOOST_VOLTAGE_CODE <= lockout ? 4'h0 : cfg.boost_voltage_code;
      BOOST_ENABLE <= (cfg.boost_voltage_code != 4'h0) && !lockout;
      SYNC_RECT_ON <= (cfg.boost_voltage_code == 4'h0) && (sink_on != 5'h00);
      LED_SINK_CODE <= lockout ? 20'h00000 : cfg.sink_current_code;
      FLASH_SINK_CODE <= lockout ? 5'h00 : applied;
      FLASH_MODE <= flash_active;
      MOVIE_MODE <= movie_req && !flash_active && !lockout;
      DETECT_ENABLE <= det_en;
      STANDBY <= (cfg.boost_voltage_code == 4'h0) && (sink_on == 5'h00) &&
                 !pin_s.flash_enable && !pin_s.movie_on;
    end
  end
endmodule : lfc_core
`default_nettype wire

// ==== hdl/lfc_pkg.sv ====
package lfc_pkg;
  // ----------------------------------------
  // serial addresses and control byte layout
  // ----------------------------------------
  localparam logic [7:0] ADDR_WRITE = 8'h94;
  localparam logic [7:0] ADDR_READ = 8'h95;
  localparam int CMD_MSB_POS = 7;
  localparam int CMD_LSB_POS = 5;
  localparam int SEL_BIT_POS = 4;
  localparam int GATE_BIT_POS = 2;
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] CMD_BOOST = 3'h0;
  localparam logic [2:0] CMD_SINK1 = 3'h1;
  localparam logic [2:0] CMD_SINK4 = 3'h4;
  localparam logic [2:0] CMD_RESERVED = 3'h5;
  localparam logic [2:0] CMD_FLASH = 3'h6;
  localparam logic [2:0] CMD_MOVIE = 3'h7;
  localparam logic [2:0] STATUS_PAD = 3'h0;
  localparam int SINK_COUNT = 4;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int FLASH_STEP_MS = 500;
  localparam int FLASH_STEP_CYCLES = CLK_HZ / 1000 * FLASH_STEP_MS;
  localparam int FLASH_CNT_W = 25;

  // ----------------------------------------
  // stored settings
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] boost_voltage_code;
    logic [SINK_COUNT-1:0][4:0] sink_current_code;
    logic [4:0] flash_current_code;
    logic [3:0] movie_current_code;
    logic movie_gated;
    logic [1:0] flash_duration;
  } lfc_cfg_t;

  localparam lfc_cfg_t CFG_RESET = '0;

  // ----------------------------------------
  // synchronised pin inputs
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] short_det;
    logic [4:0] open_det;
    logic over_temp;
    logic undervoltage_lockout;
    logic movie_on;
    logic flash_enable;
    logic sda;
    logic scl;
  } lfc_pins_t;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_AACK = 8'h04,
    ST_WDATA = 8'h08,
    ST_WACK = 8'h10,
    ST_RDATA = 8'h20,
    ST_RACK = 8'h40,
    ST_SKIP = 8'h80
  } lfc_state_t;
endpackage : lfc_pkg

// ==== sim/lfc_core_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module lfc_core_sva #(
  parameter int FLASH_STEP = 20
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic FLASH_ENABLE_INPUT,
  input wire logic UNDERVOLTAGE_LOCKOUT,
  input wire logic OVER_TEMP,
  input wire logic [3:0] BOOST_VOLTAGE_CODE,
  input wire logic BOOST_ENABLE,
  input wire logic SYNC_RECT_ON,
  input wire logic [19:0] LED_SINK_CODE,
  input wire logic [4:0] FLASH_SINK_CODE,
  input wire logic FLASH_MODE,
  input wire logic MOVIE_MODE,
  input wire logic [4:0] DETECT_ENABLE,
  input wire logic STANDBY
);
  // ----
  // flash episode length
  // ----
  logic [31:0] flash_run;
  logic [31:0] next_flash_run;
  logic [4:0] coded;
  always_comb begin
    next_flash_run = FLASH_MODE ? flash_run + 32'h1 : 32'h0;
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flash_run <= 32'h0;
    end else begin
      flash_run <= next_flash_run;
    end
  end
  assign coded = {|FLASH_SINK_CODE, |LED_SINK_CODE[19:15], |LED_SINK_CODE[14:10],
    |LED_SINK_CODE[9:5], |LED_SINK_CODE[4:0]};
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  AST_OPEN_DRAIN: assert property (SDA_OE |-> !SDA_OUT)
    else $error("data pin driven high");
  AST_BOOST_CODE: assert property (BOOST_ENABLE |-> BOOST_VOLTAGE_CODE != 4'h0)
    else $error("boost on with code zero");
  AST_SYNC_RECT: assert property (SYNC_RECT_ON |-> BOOST_VOLTAGE_CODE == 4'h0 && coded != 5'h0)
    else $error("rectifier on without cause");
  AST_FLASH_PIN: assert property (!FLASH_ENABLE_INPUT [*8] |-> !FLASH_MODE)
    else $error("flash without enable pin");
  AST_FLASH_WINS: assert property (FLASH_MODE |-> !MOVIE_MODE)
    else $error("movie beside flash");
  AST_FLASH_LIMIT: assert property (flash_run <= 4 * FLASH_STEP + 2)
    else $error("flash episode too long");
  AST_LOCKOUT: assert property (UNDERVOLTAGE_LOCKOUT [*6] |-> BOOST_VOLTAGE_CODE == 4'h0
    && LED_SINK_CODE == 20'h0 && FLASH_SINK_CODE == 5'h0 && !FLASH_MODE)
    else $error("active in lockout");
  AST_HOT_OFF: assert property (OVER_TEMP [*6] |-> !BOOST_ENABLE)
    else $error("boost on when hot");
  AST_STANDBY: assert property (STANDBY |-> BOOST_VOLTAGE_CODE == 4'h0 && LED_SINK_CODE == 20'h0)
    else $error("standby with outputs on");
  AST_DETECT: assert property ((DETECT_ENABLE & ~coded) == 5'h0)
    else $error("detect on idle sink");
endmodule : lfc_core_sva
bind lfc_core lfc_core_sva #(.FLASH_STEP(FLASH_STEP)) lfc_core_sva_inst (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .FLASH_ENABLE_INPUT(FLASH_ENABLE_INPUT), .UNDERVOLTAGE_LOCKOUT(UNDERVOLTAGE_LOCKOUT),
  .OVER_TEMP(OVER_TEMP), .BOOST_VOLTAGE_CODE(BOOST_VOLTAGE_CODE), .BOOST_ENABLE(BOOST_ENABLE),
  .SYNC_RECT_ON(SYNC_RECT_ON), .LED_SINK_CODE(LED_SINK_CODE), .FLASH_SINK_CODE(FLASH_SINK_CODE),
  .FLASH_MODE(FLASH_MODE), .MOVIE_MODE(MOVIE_MODE), .DETECT_ENABLE(DETECT_ENABLE),
  .STANDBY(STANDBY));
`default_nettype wire

// ==== sim/lfc_i2c_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module lfc_i2c_host (
  output logic scl,
  output logic pull_low,
  input wire logic sda
);
  localparam int QTR = 50;
  initial begin
    scl = 1'b1; // clock idles high between frames
    pull_low = 1'b0;
  end
  task automatic frame_start;
    pull_low = 1'b1;
    #QTR;
    scl = 1'b0;
    #QTR;
  endtask : frame_start
  task automatic frame_stop;
    pull_low = 1'b1;
    #QTR;
    scl = 1'b1;
    #QTR;
    pull_low = 1'b0;
    #(2 * QTR);
  endtask : frame_stop
  task automatic put_bit(input logic b, output logic seen);
    pull_low = ~b;
    #QTR;
    scl = 1'b1;
    seen = sda;
    #(2 * QTR);
    scl = 1'b0;
    #QTR;
  endtask : put_bit
  // msb first, ninth clock carries the acknowledge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(tx[i], rx[i]);
    end
    put_bit(1'b1, ack);
  endtask : xfer
endmodule : lfc_i2c_host
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int STEP = 20;
  localparam int LIMIT = 20000;
  logic clk, rst_n, flash_enable_input, movie_on_input, undervoltage_lockout, otemp, sda_out, sda_oe, boost_en, sync_rect;
  logic flash_mode, movie_mode, standby, scl, pull_low;
  logic [4:0] open_det, short_det, flash_code, det_en;
  logic [3:0] boost_code;
  logic [19:0] led_code, flash_len;
  logic [7:0] rd_byte;
  logic [1:0] last_ack;
  logic [23:0] exp_q[$];
  wire logic sda;
  int fails, total_checks, cycles;
  event take;
  assign sda = ~(sda_oe | pull_low);
  lfc_core #(.FLASH_STEP(STEP)) lfc_core_inst (.REF_CLK(clk), .RST_N(rst_n), .SCL(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .FLASH_ENABLE_INPUT(flash_enable_input),
    .MOVIE_ON_INPUT(movie_on_input), .UNDERVOLTAGE_LOCKOUT(undervoltage_lockout), .OVER_TEMP(otemp),
    .OPEN_DETECT(open_det), .SHORT_DETECT(short_det), .BOOST_VOLTAGE_CODE(boost_code),
    .BOOST_ENABLE(boost_en), .SYNC_RECT_ON(sync_rect), .LED_SINK_CODE(led_code),
    .FLASH_SINK_CODE(flash_code), .FLASH_MODE(flash_mode), .MOVIE_MODE(movie_mode),
    .DETECT_ENABLE(det_en), .STANDBY(standby));
  lfc_i2c_host lfc_i2c_host_inst (.scl(scl), .pull_low(pull_low), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----
  // checking
  // ----
  function automatic logic [19:0] view(input logic [3:0] sel);
    case (sel)
      4'h0: view = led_code;
      4'h1: view = {16'h0, boost_code};
      4'h2: view = {15'h0, flash_code};
      4'h3: view = {15'h0, flash_mode, movie_mode, boost_en, sync_rect, standby};
      4'h4: view = {12'h0, rd_byte};
      4'h5: view = {18'h0, last_ack};
      4'h6: view = {15'h0, det_en};
      4'h7: view = flash_len;
      default: view = {19'h0, boost_en};
    endcase
  endfunction : view
  always @(take) begin
    logic [23:0] e;
    e = exp_q.pop_front();
    total_checks++;
    if (view(e[23:20]) !== e[19:0]) begin
      fails++;
      $display("wrong value at %0t: expected %h got %h", $time, e[19:0], view(e[23:20]));
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      conclude();
    end
  end
  // ----
  // stimulus
  // ----
  task automatic note(input logic [3:0] sel, input logic [19:0] val);
    exp_q.push_back({sel, val});
    ->take;
    #0;
  endtask : note
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : settle
  task automatic frame(input logic [7:0] adr, input logic [7:0] b);
    logic [7:0] rx;
    logic a0, a1;
    lfc_i2c_host_inst.frame_start();
    lfc_i2c_host_inst.xfer(adr, rx, a0);
    if (adr == lfc_pkg::ADDR_READ) lfc_i2c_host_inst.xfer(8'hff, rd_byte, a1);
    else if (adr == lfc_pkg::ADDR_WRITE) lfc_i2c_host_inst.xfer(b, rx, a1);
    lfc_i2c_host_inst.frame_stop();
    last_ack = {a0, (adr == lfc_pkg::ADDR_WRITE) ? a1 : 1'b0};
    settle(2);
  endtask : frame
  task automatic wr(input logic [7:0] b);
    frame(lfc_pkg::ADDR_WRITE, b);
    note(4'h5, 20'h0);
  endtask : wr
  initial begin
    logic [19:0] led_exp;
    logic [3:0] v, m;
    logic [4:0] c, fc, en;
    int n;
    {rst_n, flash_enable_input, movie_on_input, undervoltage_lockout, otemp, open_det, short_det} = '0;
    void'($urandom(46724));
    led_exp = 20'h0;
    repeat (12) @(posedge clk);
    #2 rst_n = 1'b1;
    settle(4);
    note(4'h3, 20'h1);
    for (int k = 1; k <= 4; k++) begin
      c = 5'($urandom_range(31, 1));
      led_exp[(k - 1) * 5 +: 5] = c;
      wr({k[2:0], c});
      note(4'h0, led_exp);
    end
    note(4'h3, 20'h2);
    v = 4'($urandom_range(15, 1));
    wr({4'h0, v});
    note(4'h1, {16'h0, v});
    note(4'h3, 20'h4);
    wr({3'h5, 5'($urandom)});
    wr({4'h1, 4'($urandom)});
    note(4'h0, led_exp);
    note(4'h1, {16'h0, v});
    m = 4'($urandom_range(15, 1));
    wr({4'he, m});
    note(4'h2, {16'h0, m});
    note(4'h3, 20'hc);
    wr(8'hf4);
    note(4'h2, 20'h0);
    movie_on_input = 1'b1;
    settle(5);
    note(4'h2, {16'h0, m});
    fc = 5'($urandom_range(31, 1));
    wr({3'h6, fc});
    note(4'h2, {16'h0, m});
    for (int d = 0; d < 4; d++) begin
      wr({6'h3d, d[1:0]});
      flash_enable_input = 1'b1;
      settle(6);
      note(4'h2, {15'h0, fc});
      n = 6;
      while (flash_mode === 1'b1 && n < 200) begin
        settle(1);
        n++;
      end
      flash_len = 20'(n / STEP);
      settle(2);
      note(4'h7, 20'(d + 1));
      note(4'h2, {16'h0, m});
      flash_enable_input = 1'b0;
      settle(4);
    end
    wr(8'h60); // sink three switched off
    led_exp[14:10] = 5'h0;
    open_det = 5'($urandom);
    short_det = 5'($urandom);
    en = {1'b1, |led_exp[19:15], 1'b0, |led_exp[9:5], |led_exp[4:0]};
    settle(4);
    note(4'h6, {15'h0, en});
    frame(lfc_pkg::ADDR_READ, 8'h0);
    note(4'h5, 20'h0);
    note(4'h4, {15'h0, (open_det | short_det) & en});
    frame(8'h96, 8'h0);
    note(4'h5, 20'h2);
    otemp = 1'b1;
    settle(6);
    note(4'h8, 20'h0);
    otemp = 1'b0;
    settle(6);
    note(4'h8, 20'h1);
    undervoltage_lockout = 1'b1;
    settle(6);
    note(4'h0, 20'h0);
    note(4'h1, 20'h0);
    undervoltage_lockout = 1'b0;
    settle(6);
    note(4'h0, 20'h0);
    note(4'h2, 20'h0);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
